// ===== src/lbm_bucket.v
// Leaky-bucket accumulator with alarm hysteresis.
`timescale 1ns/1ns
module lbm_bucket #(
    parameter W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire cycle_end,
    input wire cycle_fault,
    input wire [1:0] decay_rate,
    input wire [W-1:0] clear_thr,
    input wire [W-1:0] upper_thr,
    input wire [W-1:0] ceiling,
    output reg [W-1:0] count_r,
    output reg alarm_r
);
    reg [3:0] good_r;
    reg [W-1:0] count_nxt;
    reg [3:0] good_nxt;
    wire [3:0] period = 4'h1 << decay_rate;

    always @* begin
        count_nxt = count_r;
        good_nxt = good_r;
        if (cycle_end) begin
            if (cycle_fault) begin
                good_nxt = 4'h0;
                if (count_r < ceiling) begin
                    count_nxt = count_r + 1'b1;
                end else begin
                    count_nxt = ceiling;
                end
            end else if (good_r + 4'h1 >= period) begin
                good_nxt = 4'h0;
                if (count_r != {W{1'b0}}) begin
                    count_nxt = count_r - 1'b1;
                end
            end else begin
                good_nxt = good_r + 4'h1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= {W{1'b0}};
            good_r <= 4'h0;
            alarm_r <= 1'b0;
        end else if (clk_en) begin
            count_r <= count_nxt;
            good_r <= good_nxt;
            if (cycle_end) begin
                if (count_nxt >= upper_thr) begin
                    alarm_r <= 1'b1;
                end else if (count_nxt <= clear_thr) begin
                    alarm_r <= 1'b0;
                end
            end
        end
    end
endmodule

// ===== src/lbm_defs.vh
// Constants for the leaky-bucket activity monitor.
`ifndef LBM_DEFS_VH
`define LBM_DEFS_VH
`define LBM_CYCLE_MS 128
`define LBM_CLK_HZ 25000000
`define LBM_CYCLE_CLKS ((`LBM_CYCLE_MS * (`LBM_CLK_HZ / 1000)))
`define LBM_OFF_CLEAR_THR 8'h00
`define LBM_OFF_CEILING 8'h04
`define LBM_OFF_UPPER_THR 8'h08
`define LBM_OFF_DECAY 8'h0C
`define LBM_OFF_STATUS 8'h10
`define LBM_RST_CLEAR_THR 8'h04
`define LBM_RST_CEILING 8'h08
`define LBM_RST_UPPER_THR 8'h06
`define LBM_RST_DECAY 2'h2
`define LBM_ST_ALARM_BIT 8
`define LBM_RESP_OKAY 2'h0
`define LBM_RESP_SLVERR 2'h2
`endif

// ===== src/lbm_monitor.v
// Leaky-bucket activity monitor top with AXI4-Lite register slave.
// Functional notes
// - Each 128 ms cycle with a failed or erratic input adds one.
// - Each run of 1, 2, 4 or 8 fault-free cycles subtracts one.
// - Alarm clears when count falls to the lower threshold.
// - Faults never raise count past the bucket size; a fault at ceiling holds count but restarts the fault-free run.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "lbm_defs.vh"
module lbm_monitor #(
    parameter CYCLE_CLKS = `LBM_CYCLE_CLKS
) (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire ref_active,
    input wire ref_fault,
    input wire [7:0] s_axil_awaddr,
    input wire s_axil_awvalid,
    output reg s_axil_awready,
    input wire [31:0] s_axil_wdata,
    input wire [3:0] s_axil_wstrb,
    input wire s_axil_wvalid,
    output reg s_axil_wready,
    output reg [1:0] s_axil_bresp,
    output reg s_axil_bvalid,
    input wire s_axil_bready,
    input wire [7:0] s_axil_araddr,
    input wire s_axil_arvalid,
    output reg s_axil_arready,
    output reg [31:0] s_axil_rdata,
    output reg [1:0] s_axil_rresp,
    output reg s_axil_rvalid,
    input wire s_axil_rready,
    output reg alarm_out_r,
    output reg [7:0] count_out_r
);
    // ==========================================================
    // Cycle timer and fault capture
    // ==========================================================
    reg [31:0] tick_r;
    reg seen_r;
    reg bad_r;
    reg cycle_end_r;
    reg cycle_fault_r;
    wire [7:0] count;
    wire alarm;
    wire tick_last = (tick_r == CYCLE_CLKS - 1);

    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_r <= 32'h0;
            seen_r <= 1'b0;
            bad_r <= 1'b0;
            cycle_end_r <= 1'b0;
            cycle_fault_r <= 1'b0;
        end else if (clk_en) begin
            cycle_end_r <= tick_last;
            if (tick_last) begin
                tick_r <= 32'h0;
                // A cycle with no activity or any erratic edge counts as faulty.
                cycle_fault_r <= !(seen_r || ref_active) || bad_r || ref_fault;
                seen_r <= 1'b0;
                bad_r <= 1'b0;
            end else begin
                tick_r <= tick_r + 32'h1;
                seen_r <= seen_r | ref_active;
                bad_r <= bad_r | ref_fault;
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    reg [7:0] clear_thr_r;
    reg [7:0] ceiling_r;
    reg [7:0] upper_thr_r;
    reg [1:0] decay_r;

    function [7:0] lbm_apply;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            lbm_apply = strb[0] ? data[7:0] : old;
        end
    endfunction

    // The write is taken only at the edge where both channels see valid and ready high.
    wire wr_go = s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    wire wr_arm = s_axil_awvalid && s_axil_wvalid && !s_axil_awready && !s_axil_bvalid;
    wire [7:0] wr_addr = s_axil_awaddr;
    wire [31:0] wr_data = s_axil_wdata;
    wire [3:0] wr_strb = s_axil_wstrb;
    wire [7:0] ceil_new = lbm_apply(ceiling_r, wr_data, wr_strb);
    wire [7:0] decay_new = lbm_apply({6'h00, decay_r}, wr_data, wr_strb);

    always @(posedge aclk) begin
        if (!aresetn) begin
            clear_thr_r <= `LBM_RST_CLEAR_THR;
            ceiling_r <= `LBM_RST_CEILING;
            upper_thr_r <= `LBM_RST_UPPER_THR;
            decay_r <= `LBM_RST_DECAY;
            s_axil_awready <= 1'b0;
            s_axil_wready <= 1'b0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= `LBM_RESP_OKAY;
        end else if (clk_en) begin
            s_axil_awready <= 1'b0;
            s_axil_wready <= 1'b0;
            if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
            if (wr_go) begin
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= `LBM_RESP_OKAY;
                case (wr_addr & 8'hFC)
                    `LBM_OFF_CLEAR_THR: clear_thr_r <= lbm_apply(clear_thr_r, wr_data, wr_strb);
                    `LBM_OFF_CEILING: begin
                        // A ceiling of zero is outside the legal range and is ignored.
                        if (ceil_new != 8'h00) begin
                            ceiling_r <= ceil_new;
                        end
                    end
                    `LBM_OFF_UPPER_THR: upper_thr_r <= lbm_apply(upper_thr_r, wr_data, wr_strb);
                    `LBM_OFF_DECAY: decay_r <= decay_new[1:0];
                    `LBM_OFF_STATUS: s_axil_bresp <= `LBM_RESP_OKAY;
                    default: s_axil_bresp <= `LBM_RESP_SLVERR;
                endcase
            end else if (wr_arm) begin
                s_axil_awready <= 1'b1;
                s_axil_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read channel
    // ==========================================================
    reg ar_busy_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ar_busy_r <= 1'b0;
            s_axil_arready <= 1'b0;
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0;
            s_axil_rresp <= `LBM_RESP_OKAY;
        end else if (clk_en) begin
            s_axil_arready <= 1'b0;
            if (s_axil_rvalid && s_axil_rready) begin
                s_axil_rvalid <= 1'b0;
                ar_busy_r <= 1'b0;
            end
            if (s_axil_arvalid && !ar_busy_r && !s_axil_arready) begin
                ar_busy_r <= 1'b1;
                s_axil_arready <= 1'b1;
            end
            if (s_axil_arvalid && s_axil_arready) begin
                s_axil_rvalid <= 1'b1;
                s_axil_rresp <= `LBM_RESP_OKAY;
                case (s_axil_araddr & 8'hFC)
                    `LBM_OFF_CLEAR_THR: s_axil_rdata <= {24'h0, clear_thr_r};
                    `LBM_OFF_CEILING: s_axil_rdata <= {24'h0, ceiling_r};
                    `LBM_OFF_UPPER_THR: s_axil_rdata <= {24'h0, upper_thr_r};
                    `LBM_OFF_DECAY: s_axil_rdata <= {30'h0, decay_r};
                    `LBM_OFF_STATUS: s_axil_rdata <= {23'h0, alarm, count};
                    default: begin
                        s_axil_rdata <= 32'h0;
                        s_axil_rresp <= `LBM_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Bucket and outputs
    // ==========================================================
    lbm_bucket #(
        .W(8)
    ) u_bucket (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .cycle_end(cycle_end_r),
        .cycle_fault(cycle_fault_r),
        .decay_rate(decay_r),
        .clear_thr(clear_thr_r),
        .upper_thr(upper_thr_r),
        .ceiling(ceiling_r),
        .count_r(count),
        .alarm_r(alarm)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm_out_r <= 1'b0;
            count_out_r <= 8'h00;
        end else if (clk_en) begin
            alarm_out_r <= alarm;
            count_out_r <= count;
        end
    end
endmodule

// ===== test/lbm_monitor_monitor.sv
// Concurrent checks on the monitor's bus handshakes and bucket outputs.
`timescale 1ns/1ns
module lbm_monitor_chk (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire s_axil_awvalid,
    input wire s_axil_wvalid,
    input wire s_axil_awready,
    input wire s_axil_wready,
    input wire s_axil_bvalid,
    input wire s_axil_bready,
    input wire s_axil_arvalid,
    input wire s_axil_arready,
    input wire s_axil_rvalid,
    input wire alarm_out_r,
    input wire [7:0] count_out_r
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_req;
        clk_en && s_axil_awvalid && s_axil_wvalid && !s_axil_bvalid && !s_axil_awready;
    endsequence
    sequence wr_ack;
        s_axil_awready && s_axil_wready && !s_axil_bvalid;
    endsequence
    count_step_a: assert property ($changed(count_out_r) |->
        (count_out_r - $past(count_out_r)) inside {8'h01, 8'hFF}) else $error("Count jumped");
    alarm_rise_a: assert property ($rose(alarm_out_r) |-> ##[0:3] count_out_r != 8'h00)
        else $error("Alarm raised on empty bucket");
    write_walk_a: assert property (wr_req |=> wr_ack ##1 s_axil_bvalid) else $error("Write not answered");
    read_walk_a: assert property (clk_en && s_axil_arvalid && !s_axil_rvalid && !s_axil_arready
        |=> s_axil_arready && !s_axil_rvalid ##1 s_axil_rvalid) else $error("Read not answered");
    bresp_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
        else $error("Write response dropped");
endmodule
bind lbm_monitor lbm_monitor_chk u_lbm_monitor_chk (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axil_awvalid(s_axil_awvalid), .s_axil_wvalid(s_axil_wvalid), .s_axil_awready(s_axil_awready),
    .s_axil_wready(s_axil_wready), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready), .s_axil_rvalid(s_axil_rvalid),
    .alarm_out_r(alarm_out_r), .count_out_r(count_out_r));

// ===== test/lbm_monitor_test.sv
// Bench for the activity monitor: register access and bucket behaviour.
`timescale 1ns/1ns
module lbm_monitor_test;
    reg aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    reg [1:0] mode = 2'h0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, ref_active, ref_fault, alarm;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] count;
    integer err_total = 0, tests_run = 0, n;
    lbm_ref_model u_lbm_ref_model (.aclk(aclk), .mode(mode), .ref_active(ref_active), .ref_fault(ref_fault));
    lbm_monitor #(.CYCLE_CLKS(8)) u_lbm_monitor (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .ref_active(ref_active), .ref_fault(ref_fault), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .alarm_out_r(alarm),
        .count_out_r(count));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task axw(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            bready <= 1'b0;
            chk(32'(bresp), 32'(er));
            @(posedge aclk);
        end
    endtask
    task axr(input [7:0] a, input [31:0] ed, input [1:0] er);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            rready <= 1'b0;
            chk(rdata, ed);
            chk(32'(rresp), 32'(er));
            @(posedge aclk);
        end
    endtask
    // Counts clock edges until the bucket shows the wanted level.
    task waitc(input [7:0] v);
        begin
            n = 0;
            while (count !== v && n < 400) begin
                @(posedge aclk);
                n = n + 1;
            end
        end
    endtask
    task conclude;
        begin
            if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial forever #20 aclk = ~aclk;
    initial begin
        #100000;
        err_total = err_total + 1;
        conclude;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h00, 32'h4, 2'h0);
        axr(8'h04, 32'h8, 2'h0);
        axr(8'h10, 32'h0, 2'h0);
        axr(8'h14, 32'h0, 2'h2);
        axw(8'h14, 32'h1, 2'h2);
        axw(8'h04, 32'h0, 2'h0);
        axr(8'h04, 32'h8, 2'h0);
        axw(8'h04, 32'h3, 2'h0);
        axw(8'h08, 32'h3, 2'h0);
        axw(8'h00, 32'h1, 2'h0);
        axw(8'h0C, 32'h1, 2'h0);
        mode <= 2'h1;
        repeat (60) @(posedge aclk);
        axr(8'h10, 32'h103, 2'h0);
        mode <= 2'h0;
        clk_en <= 1'b0;
        repeat (40) @(posedge aclk);
        chk(32'(count), 32'h3);
        clk_en <= 1'b1;
        waitc(8'h2);
        chk(32'(alarm), 32'h1);
        waitc(8'h1);
        chk(32'(n), 32'd16);
        repeat (3) @(posedge aclk);
        chk(32'(alarm), 32'h0);
        waitc(8'h0);
        repeat (40) @(posedge aclk);
        chk(32'(count), 32'h0);
        mode <= 2'h2;
        waitc(8'h1);
        waitc(8'h2);
        chk(32'(n), 32'd8);
        waitc(8'h3);
        repeat (40) @(posedge aclk);
        axr(8'h10, 32'h103, 2'h0);
        conclude;
    end
endmodule

// ===== test/lbm_ref_model.sv
// Reference input model: healthy, silent or erratic.
`timescale 1ns/1ns
module lbm_ref_model (
    input wire aclk,
    input wire [1:0] mode,
    output reg ref_active = 1'b0,
    output reg ref_fault = 1'b0
);
    always @(posedge aclk) begin
        ref_active <= (mode != 2'h1) & ~ref_active;
        ref_fault <= (mode == 2'h2);
    end
endmodule
